/* hw/rtxi_cfg.svh */
`ifndef RTXI_CFG_SVH
`define RTXI_CFG_SVH

`define RTXI_OFF_CTRL 8'h00
`define RTXI_OFF_CORE 8'h04
`define RTXI_OFF_SHADOW 8'h08
`define RTXI_OFF_STAT 8'h0C

`define RTXI_CTRL_RST 2'h1
`define RTXI_CTRL_EN 0
`define RTXI_CTRL_HIGH 1

`define RTXI_CORE_W_LSB 0
`define RTXI_CORE_ST_LSB 8
`define RTXI_CORE_BANK_LSB 16
`define RTXI_CORE_IRQ_HI 24
`define RTXI_CORE_IRQ_LO 25
`define RTXI_STAT_BUSY 0
`define RTXI_STAT_SKIP 1

`define RTXI_ST_Z 2
`define RTXI_ST_N 4

`define RTXI_ENC_RET_IRQ 15'h0008
`define RTXI_ENC_RET_LIT 8'h0C
`define RTXI_ENC_XOR_LIT 8'h0A
`define RTXI_ENC_TEST_SKIP 7'h33
`define RTXI_BIT_ACCESS 8
`define RTXI_BIT_SHADOW 0

`define RTXI_Q1 2'h0
`define RTXI_Q2 2'h1
`define RTXI_Q4 2'h3

`define RTXI_ACC_LO 4'h0
`define RTXI_ACC_HI 4'hF
`define RTXI_ACC_SPLIT 7

`define RTXI_EXTRA_RET 2'h1
`define RTXI_EXTRA_SKIP 2'h1
`define RTXI_EXTRA_SKIP2 2'h2

`define RTXI_RESP_OK 2'h0
`define RTXI_RESP_ERR 2'h2

`endif

/* hw/rtxi_pkg.sv */
package rtxi_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    RETURN_FROM_INTERRUPT_OP,
    RETURN_WITH_LITERAL_OP,
    TEST_SKIP_IF_ZERO_OP,
    XOR_LITERAL_OP
  } rtxi_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_WAIT
  } rtxi_state_t;

endpackage : rtxi_pkg

/* hw/rtxi_reg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface rtxi_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_hit,
                 output rd_addr, input rd_data, input rd_hit);
  modport core (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_hit,
                input rd_addr, output rd_data, output rd_hit);
endinterface : rtxi_reg_if
`default_nettype wire

/* hw/rtxi_axil_slave.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rtxi_cfg.svh"
module rtxi_axil_slave
  import rtxi_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  rtxi_reg_if.slave reg_if
);

  logic aw_held, w_held, ar_held;
  logic next_aw_held, next_w_held, next_ar_held;
  logic [7:0] aw_addr, ar_addr, next_aw_addr, next_ar_addr;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  assign reg_if.wr_en = aw_held && w_held && !bvalid_o;
  assign reg_if.wr_addr = aw_addr;
  assign reg_if.wr_data = w_data;
  assign reg_if.wr_strb = w_strb;
  assign reg_if.rd_addr = ar_addr;

  always_comb begin
    next_aw_held = aw_held || (awvalid_i && awready_o);
    next_aw_addr = (awvalid_i && awready_o) ? awaddr_i : aw_addr;
    next_w_held = w_held || (wvalid_i && wready_o);
    next_w_data = (wvalid_i && wready_o) ? wdata_i : w_data;
    next_w_strb = (wvalid_i && wready_o) ? wstrb_i : w_strb;
    next_bvalid = bvalid_o && !bready_i;
    next_bresp = bresp_o;
    if (reg_if.wr_en) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_if.wr_hit ? `RTXI_RESP_OK : `RTXI_RESP_ERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_ar_held = ar_held || (arvalid_i && arready_o);
    next_ar_addr = (arvalid_i && arready_o) ? araddr_i : ar_addr;
    next_rvalid = rvalid_o && !rready_i;
    next_rdata = rdata_o;
    next_rresp = rresp_o;
    if (ar_held && !rvalid_o) begin
      next_ar_held = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = reg_if.rd_hit ? reg_if.rd_data : 32'h0000_0000;
      next_rresp = reg_if.rd_hit ? `RTXI_RESP_OK : `RTXI_RESP_ERR;
    end
    next_arready = !next_ar_held && !next_rvalid;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      ar_held <= 1'b0;
      aw_addr <= 8'h00;
      ar_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      arready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= 2'h0;
      rvalid_o <= 1'b0;
      rresp_o <= 2'h0;
      rdata_o <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      ar_held <= next_ar_held;
      aw_addr <= next_aw_addr;
      ar_addr <= next_ar_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready_o <= next_awready;
      wready_o <= next_wready;
      arready_o <= next_arready;
      bvalid_o <= next_bvalid;
      bresp_o <= next_bresp;
      rvalid_o <= next_rvalid;
      rresp_o <= next_rresp;
      rdata_o <= next_rdata;
    end
  end

endmodule : rtxi_axil_slave
`default_nettype wire

/* hw/rtxi_exec_top.sv */
// What this block does
// [RULE_01] Return-from-interrupt pops stack, loads PC, two cycles.
// [RULE_02] Return-from-interrupt sets high or low enable.
// [RULE_03] With s=1, restore working, status, bank shadows.
// [RULE_04] With s=0, registers and PC latches untouched.
// [RULE_05] Return-with-literal writes literal to W, two cycles.
// [RULE_06] Return-with-literal loads PC from stack, pops.
// [RULE_07] Return-with-literal leaves PC latches unchanged.
// [RULE_08] Test-skip reads register, no flags, one cycle.
// [RULE_09] Zero register discards next instruction, two cycles.
// [RULE_10] Skipped two-word instruction makes three cycles.
// [RULE_11] Access bit zero selects access bank, else bank.
// [RULE_12] XOR literal into W, one cycle, N Z only.
// [RULE_13] Z when result zero, N equals bit seven.
`timescale 1ns/10ps
`default_nettype none
`include "rtxi_cfg.svh"
module rtxi_exec_top
  import rtxi_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic next_two_word_i,
  output logic q1_o,
  output logic busy_o,
  output logic discard_o,
  input wire logic [20:0] stack_top_value_i,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [20:0] pc_value_o,
  output logic file_rd_o,
  output logic [11:0] file_addr_o,
  input wire logic [7:0] file_rdata_i,
  input wire logic irq_entry_i,
  output logic global_irq_enable_high_o,
  output logic peripheral_irq_enable_low_o,
  output logic [7:0] w_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  rtxi_reg_if reg_bus ();

  rtxi_axil_slave u_slave (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .reg_if(reg_bus)
  );

  function automatic rtxi_op_t decode(input logic [15:0] ins);
    if (ins[15:1] == `RTXI_ENC_RET_IRQ) decode = RETURN_FROM_INTERRUPT_OP;
    else if (ins[15:8] == `RTXI_ENC_RET_LIT) decode = RETURN_WITH_LITERAL_OP;
    else if (ins[15:8] == `RTXI_ENC_XOR_LIT) decode = XOR_LITERAL_OP;
    else if (ins[15:9] == `RTXI_ENC_TEST_SKIP) decode = TEST_SKIP_IF_ZERO_OP;
    else decode = OP_NONE;
  endfunction : decode

  function automatic logic [31:0] pack_core(input logic [7:0] wv, input logic [4:0] st,
                                            input logic [3:0] bs, input logic gh, input logic gl);
    pack_core = 32'h0000_0000;
    pack_core[`RTXI_CORE_W_LSB +: 8] = wv;
    pack_core[`RTXI_CORE_ST_LSB +: 5] = st;
    pack_core[`RTXI_CORE_BANK_LSB +: 4] = bs;
    pack_core[`RTXI_CORE_IRQ_HI] = gh;
    pack_core[`RTXI_CORE_IRQ_LO] = gl;
  endfunction : pack_core

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction : merge

  rtxi_state_t state, next_state;
  logic [1:0] phase, next_phase, rem, next_rem;
  logic [15:0] ir, next_ir;
  logic [7:0] w, next_w, shadow_working_reg, next_shadow_w;
  logic [4:0] status, next_status, shadow_status_reg, next_shadow_st;
  logic [3:0] bank_select_reg, next_bank_select, shadow_bank_select, next_shadow_bs;
  logic irq_en_high, next_irq_en_high, irq_en_low, next_irq_en_low;
  logic [1:0] ctrl, next_ctrl;
  logic last_skip, next_skip, next_busy, next_q1, next_discard, next_pop, next_pc_load;
  logic [20:0] next_pc_value;
  logic next_file_rd;
  logic [11:0] next_file_addr;
  logic [31:0] core_new;
  logic [1:0] extra;
  logic [7:0] xor_res;
  rtxi_op_t ir_op;
  logic accept, exec;

  assign ir_op = decode(ir);
  assign accept = (state == ST_IDLE) && (phase == `RTXI_Q1) && instr_valid_i && ctrl[`RTXI_CTRL_EN];
  assign exec = (state == ST_RUN) && (phase == `RTXI_Q4);
  assign xor_res = w ^ ir[7:0];

  assign reg_bus.wr_hit = (reg_bus.wr_addr == `RTXI_OFF_CTRL) || (reg_bus.wr_addr == `RTXI_OFF_CORE);
  assign reg_bus.rd_hit = (reg_bus.rd_addr == `RTXI_OFF_CTRL) || (reg_bus.rd_addr == `RTXI_OFF_CORE) ||
                          (reg_bus.rd_addr == `RTXI_OFF_SHADOW) || (reg_bus.rd_addr == `RTXI_OFF_STAT);

  always_comb begin
    reg_bus.rd_data = 32'h0000_0000;
    case (reg_bus.rd_addr)
      `RTXI_OFF_CTRL: reg_bus.rd_data[1:0] = ctrl;
      `RTXI_OFF_CORE: reg_bus.rd_data = pack_core(w, status, bank_select_reg, irq_en_high, irq_en_low);
      `RTXI_OFF_SHADOW: reg_bus.rd_data = pack_core(shadow_working_reg, shadow_status_reg,
                                                    shadow_bank_select, 1'b0, 1'b0);
      `RTXI_OFF_STAT: begin
        reg_bus.rd_data[`RTXI_STAT_BUSY] = busy_o;
        reg_bus.rd_data[`RTXI_STAT_SKIP] = last_skip;
      end
      default: reg_bus.rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_phase = phase + 2'h1;
    next_q1 = (next_phase == `RTXI_Q1);
    next_state = state;
    next_rem = rem;
    next_ir = ir;
    next_busy = busy_o;
    next_w = w;
    next_status = status;
    next_bank_select = bank_select_reg;
    next_irq_en_high = irq_en_high;
    next_irq_en_low = irq_en_low;
    next_ctrl = ctrl;
    next_skip = last_skip;
    next_discard = 1'b0;
    next_pop = 1'b0;
    next_pc_load = 1'b0;
    next_pc_value = pc_value_o;
    next_file_rd = file_rd_o;
    next_file_addr = file_addr_o;
    extra = 2'h0;
    core_new = merge(pack_core(w, status, bank_select_reg, irq_en_high, irq_en_low), reg_bus.wr_data, reg_bus.wr_strb);
    next_shadow_w = irq_entry_i ? w : shadow_working_reg;
    next_shadow_st = irq_entry_i ? status : shadow_status_reg;
    next_shadow_bs = irq_entry_i ? bank_select_reg : shadow_bank_select;
    case (state)
      ST_IDLE: begin
        if (reg_bus.wr_en && reg_bus.wr_addr == `RTXI_OFF_CTRL) begin
          next_ctrl = reg_bus.wr_strb[0] ? reg_bus.wr_data[1:0] : ctrl;
        end
        if (reg_bus.wr_en && reg_bus.wr_addr == `RTXI_OFF_CORE) begin
          next_w = core_new[`RTXI_CORE_W_LSB +: 8];
          next_status = core_new[`RTXI_CORE_ST_LSB +: 5];
          next_bank_select = core_new[`RTXI_CORE_BANK_LSB +: 4];
          next_irq_en_high = core_new[`RTXI_CORE_IRQ_HI];
          next_irq_en_low = core_new[`RTXI_CORE_IRQ_LO];
        end
        if (accept) begin
          next_ir = instr_i;
          next_state = ST_RUN;
          next_busy = 1'b1;
        end
      end
      ST_RUN: begin
        if (phase == `RTXI_Q2 && ir_op == TEST_SKIP_IF_ZERO_OP) begin
          next_file_rd = 1'b1;
          if (!ir[`RTXI_BIT_ACCESS]) begin
            next_file_addr = {ir[`RTXI_ACC_SPLIT] ? `RTXI_ACC_HI : `RTXI_ACC_LO, ir[7:0]}; // RULE_11
          end else begin
            next_file_addr = {bank_select_reg, ir[7:0]}; // RULE_11
          end
        end
        if (phase == `RTXI_Q4) begin
          next_file_rd = 1'b0;
          case (ir_op)
            RETURN_FROM_INTERRUPT_OP: begin
              next_pop = 1'b1; // RULE_01
              next_pc_load = 1'b1;
              next_pc_value = stack_top_value_i;
              extra = `RTXI_EXTRA_RET; // RULE_01
              if (ctrl[`RTXI_CTRL_HIGH]) next_irq_en_high = 1'b1; // RULE_02
              else next_irq_en_low = 1'b1; // RULE_02
              if (ir[`RTXI_BIT_SHADOW]) begin // RULE_04
                next_w = shadow_working_reg; // RULE_03
                next_status = shadow_status_reg;
                next_bank_select = shadow_bank_select;
              end
            end
            RETURN_WITH_LITERAL_OP: begin
              next_w = ir[7:0]; // RULE_05
              next_pop = 1'b1; // RULE_06
              next_pc_load = 1'b1;
              next_pc_value = stack_top_value_i; // RULE_07
              extra = `RTXI_EXTRA_RET; // RULE_05
            end
            TEST_SKIP_IF_ZERO_OP: begin
              next_skip = (file_rdata_i == 8'h00); // RULE_08
              if (file_rdata_i == 8'h00) begin
                next_discard = 1'b1; // RULE_09
                extra = next_two_word_i ? `RTXI_EXTRA_SKIP2 : `RTXI_EXTRA_SKIP; // RULE_10
              end
            end
            XOR_LITERAL_OP: begin
              next_w = xor_res; // RULE_12
              next_status[`RTXI_ST_Z] = (xor_res == 8'h00); // RULE_13
              next_status[`RTXI_ST_N] = xor_res[7]; // RULE_13
            end
            default: extra = 2'h0;
          endcase
          if (extra == 2'h0) begin
            next_state = ST_IDLE;
            next_busy = 1'b0;
          end else begin
            next_state = ST_WAIT;
            next_rem = extra;
          end
        end
      end
      ST_WAIT: begin
        if (phase == `RTXI_Q4) begin
          next_rem = rem - 2'h1;
          if (rem == 2'h1) begin
            next_state = ST_IDLE;
            next_busy = 1'b0;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      phase <= `RTXI_Q1;
      rem <= 2'h0;
      ir <= 16'h0000;
      w <= 8'h00;
      status <= 5'h00;
      bank_select_reg <= 4'h0;
      shadow_working_reg <= 8'h00;
      shadow_status_reg <= 5'h00;
      shadow_bank_select <= 4'h0;
      irq_en_high <= 1'b0;
      irq_en_low <= 1'b0;
      ctrl <= `RTXI_CTRL_RST;
      last_skip <= 1'b0;
      q1_o <= 1'b0;
      busy_o <= 1'b0;
      discard_o <= 1'b0;
      stack_pop_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_value_o <= 21'h00_0000;
      file_rd_o <= 1'b0;
      file_addr_o <= 12'h000;
    end else begin
      state <= next_state;
      phase <= next_phase;
      rem <= next_rem;
      ir <= next_ir;
      w <= next_w;
      status <= next_status;
      bank_select_reg <= next_bank_select;
      shadow_working_reg <= next_shadow_w;
      shadow_status_reg <= next_shadow_st;
      shadow_bank_select <= next_shadow_bs;
      irq_en_high <= next_irq_en_high;
      irq_en_low <= next_irq_en_low;
      ctrl <= next_ctrl;
      last_skip <= next_skip;
      q1_o <= next_q1;
      busy_o <= next_busy;
      discard_o <= next_discard;
      stack_pop_o <= next_pop;
      pc_load_o <= next_pc_load;
      pc_value_o <= next_pc_value;
      file_rd_o <= next_file_rd;
      file_addr_o <= next_file_addr;
    end
  end

  assign w_o = w;
  assign global_irq_enable_high_o = irq_en_high;
  assign peripheral_irq_enable_low_o = irq_en_low;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_RET_IRQ_POP: assert property (exec && ir_op == RETURN_FROM_INTERRUPT_OP |=> // RULE_01
    stack_pop_o && pc_load_o && pc_value_o == $past(stack_top_value_i)) else $error("return pop missing");
  AST_RET_IRQ_TWO: assert property (accept && decode(instr_i) == RETURN_FROM_INTERRUPT_OP |=> // RULE_01
    busy_o [*7] ##1 !busy_o) else $error("return not two cycles");
  AST_IRQ_EN_SET: assert property (exec && ir_op == RETURN_FROM_INTERRUPT_OP |=> // RULE_02
    ($past(ctrl[`RTXI_CTRL_HIGH]) ? irq_en_high : irq_en_low)) else $error("enable bit not set");
  AST_SHADOW_BACK: assert property (exec && ir_op == RETURN_FROM_INTERRUPT_OP && ir[`RTXI_BIT_SHADOW] |=> // RULE_03
    w == $past(shadow_working_reg) && status == $past(shadow_status_reg) &&
    bank_select_reg == $past(shadow_bank_select)) else $error("no restore");
  AST_NO_RESTORE: assert property (exec && ir_op == RETURN_FROM_INTERRUPT_OP && !ir[`RTXI_BIT_SHADOW] |=> // RULE_04
    $stable(w) && $stable(status) && $stable(bank_select_reg)) else $error("registers changed");
  AST_RET_LIT_W: assert property (exec && ir_op == RETURN_WITH_LITERAL_OP |=> // RULE_05
    w == $past(ir[7:0]) && $stable(status) && stack_pop_o ##1 busy_o [*3] ##1 !busy_o)
    else $error("literal return bad");
  AST_TEST_ONE: assert property (exec && ir_op == TEST_SKIP_IF_ZERO_OP && file_rdata_i != 8'h00 |=> // RULE_08
    !busy_o && !discard_o && $stable(status)) else $error("test took extra cycles");
  AST_TEST_SKIP: assert property (exec && ir_op == TEST_SKIP_IF_ZERO_OP && file_rdata_i == 8'h00 && // RULE_09
    !next_two_word_i |=> discard_o && busy_o [*4] ##1 !busy_o) else $error("skip wrong");
  AST_TEST_THREE: assert property (exec && ir_op == TEST_SKIP_IF_ZERO_OP && file_rdata_i == 8'h00 && // RULE_10
    next_two_word_i |=> busy_o [*8] ##1 !busy_o) else $error("two word skip wrong");
  AST_ACCESS_BANK: assert property (file_rd_o && !ir[`RTXI_BIT_ACCESS] |-> // RULE_11
    file_addr_o[11:8] == (ir[`RTXI_ACC_SPLIT] ? `RTXI_ACC_HI : `RTXI_ACC_LO)) else $error("bank wrong");
  AST_XOR_RESULT: assert property (exec && ir_op == XOR_LITERAL_OP |=> // RULE_12
    w == ($past(w) ^ $past(ir[7:0])) && !busy_o) else $error("xor wrong");
  AST_XOR_FLAGS: assert property (exec && ir_op == XOR_LITERAL_OP |=> // RULE_13
    status[`RTXI_ST_Z] == (w == 8'h00) && status[`RTXI_ST_N] == w[7]) else $error("xor flags wrong");

endmodule : rtxi_exec_top
`default_nettype wire

/* verif/rtxi_partner_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rtxi_partner_model (
  input wire logic clk_sys_i,
  input wire logic stack_pop_i,
  output logic [20:0] stack_top_value_o,
  input wire logic file_rd_i,
  input wire logic [11:0] file_addr_i,
  output logic [7:0] file_rdata_o
);
  logic [20:0] stk [0:3];
  logic [1:0] sp;
  initial begin
    stk[0] = 21'h001234;
    stk[1] = 21'h0ABCDE;
    stk[2] = 21'h1F0F0F;
    stk[3] = 21'h000100;
    sp = 2'h3;
  end
  // The top entry is always offered; a pop retires it so the next return sees the entry below.
  assign stack_top_value_o = stk[sp];
  always @(posedge clk_sys_i) begin
    if (stack_pop_i === 1'b1) begin
      sp <= sp - 2'h1;
    end
  end
  // Each location reads back its offset, so offset zero reads zero; off a read the line shows the inverse.
  assign file_rdata_o = file_rd_i ? file_addr_i[7:0] : ~file_addr_i[7:0];
endmodule : rtxi_partner_model
`default_nettype wire

/* verif/return_test_xor_instr_exec_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rtxi_cfg.svh"
module return_test_xor_instr_exec_test;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic next_two_word_i = 1'b0;
  logic irq_entry_i = 1'b0;
  logic q1_o, busy_o, discard_o, stack_pop_o, pc_load_o, file_rd_o;
  logic global_irq_enable_high_o, peripheral_irq_enable_low_o;
  logic [20:0] stack_top_value_i, pc_value_o;
  logic [11:0] file_addr_o;
  logic [7:0] file_rdata_i, w_o;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h00000000;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [31:0] s_axi_rdata_o, rd;
  logic [11:0] seen_addr;
  logic [15:0] tst_op [4] = '{16'h6600, 16'h6690, 16'h6722, 16'h6700};
  logic [3:0] tst_tw = 4'b1000;
  int fail_count = 0;
  int cmp_count = 0;
  int pops, loads, discs;

  rtxi_exec_top rtxi_exec_top_i (.clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .next_two_word_i, .q1_o,
    .busy_o, .discard_o, .stack_top_value_i, .stack_pop_o, .pc_load_o, .pc_value_o, .file_rd_o, .file_addr_o,
    .file_rdata_i, .irq_entry_i, .global_irq_enable_high_o, .peripheral_irq_enable_low_o, .w_o,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);

  rtxi_partner_model rtxi_partner_model_i (.clk_sys_i, .stack_pop_i(stack_pop_o),
    .stack_top_value_o(stack_top_value_i), .file_rd_i(file_rd_o), .file_addr_i(file_addr_o),
    .file_rdata_o(file_rdata_i));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // A wait that runs out is reported as a mismatch and ends the run.
  task timeout;
    chk(32'h0000DEAD, 32'h00000000);
    finish_test;
  endtask : timeout

  task axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1) begin
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
    if (i == 40) timeout;
    chk({30'h0, resp}, {30'h0, `RTXI_RESP_OK});
  endtask : axw

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    int i;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1) begin
        rd = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
    if (i == 40) timeout;
    chk(rd, exp);
    chk({30'h0, resp}, {30'h0, exp_resp});
  endtask : rdchk

  // Offers one instruction at the next free Q1 and counts its clocks, the Q1 clock that takes it included.
  task exec(input logic [15:0] op, input logic tw, output int cyc);
    int i;
    @(posedge clk_sys_i);
    instr_i <= op;
    next_two_word_i <= tw;
    instr_valid_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (q1_o === 1'b1 && busy_o === 1'b0) break;
    end
    if (i == 20) timeout;
    instr_valid_i <= 1'b0;
    pops = 0;
    loads = 0;
    discs = 0;
    seen_addr = 'x;
    for (i = 1; i <= 16; i++) begin
      @(posedge clk_sys_i);
      #1;
      pops += (stack_pop_o === 1'b1);
      loads += (pc_load_o === 1'b1);
      discs += (discard_o === 1'b1);
      if (file_rd_o === 1'b1) seen_addr = file_addr_o;
      if (busy_o !== 1'b1) break;
    end
    if (i > 16) timeout;
    cyc = i + 1;
  endtask : exec

  initial begin
    int c;
    logic z;
    logic [11:0] ea;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdchk(`RTXI_OFF_CTRL, 32'h00000001, `RTXI_RESP_OK);
    rdchk(`RTXI_OFF_CORE, 32'h00000000, `RTXI_RESP_OK);
    rdchk(8'h10, 32'h00000000, `RTXI_RESP_ERR);
    $display("reset test done");
    axw(`RTXI_OFF_CORE, 32'h000001B5);
    exec(16'h0AAF, 1'b0, c);
    chk(c, 4);
    rdchk(`RTXI_OFF_CORE, 32'h0000011A, `RTXI_RESP_OK);
    exec(16'h0A1A, 1'b0, c);
    rdchk(`RTXI_OFF_CORE, 32'h00000500, `RTXI_RESP_OK);
    exec(16'h0A80, 1'b0, c);
    rdchk(`RTXI_OFF_CORE, 32'h00001180, `RTXI_RESP_OK);
    $display("xor test done");
    exec(16'h0C5A, 1'b0, c);
    chk(c, 8);
    chk(pops * 16 + loads, 32'h00000011);
    chk(pc_value_o, 21'h000100);
    rdchk(`RTXI_OFF_CORE, 32'h0000115A, `RTXI_RESP_OK);
    $display("return literal test done");
    axw(`RTXI_OFF_CORE, 32'h00030511);
    @(posedge clk_sys_i);
    irq_entry_i <= 1'b1;
    @(posedge clk_sys_i);
    irq_entry_i <= 1'b0;
    rdchk(`RTXI_OFF_SHADOW, 32'h00030511, `RTXI_RESP_OK);
    axw(`RTXI_OFF_CORE, 32'h00050022);
    exec(16'h0010, 1'b0, c);
    chk(c, 8);
    chk(pops * 16 + loads, 32'h00000011);
    chk(pc_value_o, 21'h1F0F0F);
    chk({global_irq_enable_high_o, peripheral_irq_enable_low_o}, 2'b01);
    rdchk(`RTXI_OFF_CORE, 32'h02050022, `RTXI_RESP_OK);
    axw(`RTXI_OFF_CTRL, 32'h00000003);
    exec(16'h0011, 1'b0, c);
    chk(c, 8);
    chk(pc_value_o, 21'h0ABCDE);
    chk(w_o, 8'h11);
    rdchk(`RTXI_OFF_CORE, 32'h03030511, `RTXI_RESP_OK);
    $display("return from interrupt test done");
    axw(`RTXI_OFF_CORE, 32'h00050000);
    for (int k = 0; k < 4; k++) begin
      exec(tst_op[k], tst_tw[k], c);
      ea = tst_op[k][8] ? {4'h5, tst_op[k][7:0]} : {(tst_op[k][7] ? 4'hF : 4'h0), tst_op[k][7:0]};
      z = (tst_op[k][7:0] == 8'h00);
      chk(seen_addr, ea);
      chk(c, z ? (tst_tw[k] ? 12 : 8) : 4);
      chk(discs, z);
      rdchk(`RTXI_OFF_STAT, {30'h0, z, 1'b0}, `RTXI_RESP_OK);
    end
    rdchk(`RTXI_OFF_CORE, 32'h00050000, `RTXI_RESP_OK);
    $display("test skip test done");
    finish_test;
  end
endmodule : return_test_xor_instr_exec_test
`default_nettype wire
